// File: hw/sbp_pkg.sv
package sbp_pkg;
  // Pin widths
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  // Burst counter width
  localparam int STEP_W = 2;
  // Write buffer depth
  localparam int BUF_DEPTH = 4;
  // Buffer entry layout {mask, addr, data}
  localparam int ENT_DATA_LSB = 0;
  localparam int ENT_ADDR_LSB = DATA_W;
  localparam int ENT_MASK_LSB = DATA_W + ADDR_W;
  localparam int ENT_W = DATA_W + ADDR_W + LANES;
  // Enabled edges from capture to data edge
  localparam int DATA_LAT = 2;
  // Reset values
  localparam logic [STEP_W-1:0] STEP_RST = 2'h0;
  localparam logic [LANES-1:0] MASK_RST = 4'hf;
  // Burst state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD = 3'b010,
    ST_WR = 3'b100
  } sbp_state_t;
endpackage

// File: hw/sbp_fifo.sv
`timescale 1ns/10ps
module sbp_fifo #(
  parameter int WIDTH = sbp_pkg::ENT_W,
  parameter int DEPTH = sbp_pkg::BUF_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [DEPTH*WIDTH-1:0] view_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  // Pointers wrap freely only at a power of two
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("sbp_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
  logic [PW-1:0] rd_r; // Head slot
  logic [PW-1:0] wr_r; // Tail slot
  logic [PW:0] cnt_r; // Fill level
  logic push;
  logic pop;

  // Handshakes; a full buffer still takes a word while it pops
  assign out_valid_o = (cnt_r != '0);
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_r != FULL) || pop;
  assign push = in_valid_i && in_ready_o;
  assign out_data_o = mem_r[rd_r];
  assign level_o = cnt_r;

  // Entries seen from head to tail
  for (genvar k = 0; k < DEPTH; k++) begin : g_view
    assign view_o[k*WIDTH +: WIDTH] = mem_r[PW'(rd_r + PW'(k))];
  end

  // Storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  // Pointer and level update
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// File: hw/sbp_port.sv
`timescale 1ns/10ps
// Behaviour
// R01: Continuing burst ignores read/write select
// R02: Burst direction fixed at load
// R03: Load with advance low ends burst
// R04: Burst steps two low address bits
// R05: Write burst words go to sequence addresses
// R06: Write starts when select low at load
// R07: Master drives byte masks on writes
// R08: Byte mask leads its data two cycles
// R09: Select needs secondary high, others low
// R10: Gated edge ignores all inputs
// R11: Gated edge holds every register
// R12: Any inactive select starts deselect
// R13: Bus floats two cycles after deselect
// R14: Pending transfers finish before release
// R15: Data two enabled cycles after capture
// R16: Order select low linear, else interleaved
// R17: Output enable pin disables outputs anytime
module sbp_port #(
  parameter int ADDR_W = sbp_pkg::ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic write_n_i,
  input wire logic advance_or_load_i,
  input wire logic burst_order_select_i,
  input wire logic [sbp_pkg::LANES-1:0] byte_write_mask_n_i,
  input wire logic chip_select_primary_n_i,
  input wire logic chip_select_secondary_i,
  input wire logic chip_select_tertiary_n_i,
  input wire logic clock_gate_n_i,
  input wire logic output_enable_n_i,
  input wire logic [sbp_pkg::DATA_W-1:0] data_i,
  output logic [sbp_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic wr_buf_ready_o
);
  localparam int DW = sbp_pkg::DATA_W;
  localparam int LN = sbp_pkg::LANES;
  localparam int LW = sbp_pkg::LANE_W;
  localparam int SW = sbp_pkg::STEP_W;
  localparam int BD = sbp_pkg::BUF_DEPTH;
  localparam int EW = DW + ADDR_W + LN; // Entry sized to this address width
  localparam int HI = ADDR_W - SW;
  localparam int LVW = $clog2(BD) + 1;
  localparam logic [LVW-1:0] BUF_FULL = LVW'(BD);

  // Address must hold more than the burst bits
  if (ADDR_W <= SW || ADDR_W > 24) begin : g_bad_addr
    $error("sbp_port address width out of range");
  end

  // Three-way select decode
  function automatic logic sel_decode(
    input logic p_n,
    input logic s,
    input logic t_n
  );
    sel_decode = !p_n && s && !t_n;
  endfunction

  // Low address bits for a burst step
  function automatic logic [SW-1:0] burst_lo(
    input logic [SW-1:0] base,
    input logic [SW-1:0] step,
    input logic ilv
  );
    if (ilv) begin
      burst_lo = base ^ step;
    end else begin
      burst_lo = SW'(base + step);
    end
  endfunction

  // Edge enable from clock gate pin
  logic en;
  logic sel; // Device selected
  logic load; // New address this edge
  logic op_go; // Transfer captured
  logic op_wr; // Captured transfer writes
  logic [ADDR_W-1:0] op_addr; // Captured word
  logic [SW-1:0] nxt_step; // Following step

  sbp_pkg::sbp_state_t state_r; // Burst state
  logic [ADDR_W-1:0] base_r; // Loaded base
  logic [SW-1:0] step_r; // Burst step
  logic lbo_r; // Order at load

  // Address stage
  logic s1_vld_r;
  logic s1_wr_r;
  logic [ADDR_W-1:0] s1_addr_r;
  logic [LN-1:0] s1_mask_r;
  // Data stage
  logic s2_vld_r;
  logic s2_wr_r;
  logic [ADDR_W-1:0] s2_addr_r;
  logic [LN-1:0] s2_mask_r;

  logic dq_oe_r; // Output drive stage

  // Write buffer links
  logic buf_in_valid;
  logic buf_in_ready;
  logic [EW-1:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [EW-1:0] buf_out_data;
  logic [BD*EW-1:0] buf_view;
  logic [LVW-1:0] buf_level;
  logic buf_pop;

  // Storage array
  logic [DW-1:0] mem_r [2**ADDR_W];
  logic [DW-1:0] rd_word; // Read with buffer merge

  // R10: gated edge ignored
  assign en = !clock_gate_n_i;
  // R09: select polarity
  assign sel = sel_decode(chip_select_primary_n_i,
                          chip_select_secondary_i,
                          chip_select_tertiary_n_i);
  assign load = !advance_or_load_i;
  assign nxt_step = SW'(step_r + 1'b1);

  // Decode of the transfer taken this edge
  always_comb begin
    // R12: any inactive select, no transfer
    op_go = sel && (load || state_r != sbp_pkg::ST_IDLE);
    if (load) begin
      // R02: direction from load-edge select
      op_wr = !write_n_i;
      op_addr = address_i;
    end else begin
      // R01: select ignored while continuing
      op_wr = (state_r == sbp_pkg::ST_WR);
      // R04: only two low bits advance
      op_addr = {base_r[ADDR_W-1:SW],
                 burst_lo(base_r[SW-1:0], nxt_step, lbo_r)};
    end
  end

  // Burst counter and direction
  // R11: all registers hold on gated edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_r <= sbp_pkg::ST_IDLE;
      base_r <= '0;
      step_r <= sbp_pkg::STEP_RST;
      lbo_r <= 1'b0;
    end else if (en) begin
      if (!sel) begin
        // R12: deselect stops the burst
        state_r <= sbp_pkg::ST_IDLE;
      end else if (load) begin
        // R03: load ends old burst
        // R06: write on select low
        state_r <= write_n_i ? sbp_pkg::ST_RD : sbp_pkg::ST_WR;
        base_r <= address_i;
        step_r <= sbp_pkg::STEP_RST;
        lbo_r <= burst_order_select_i;
      end else if (state_r != sbp_pkg::ST_IDLE) begin
        // R16: wraps after four words
        step_r <= nxt_step;
      end
    end
  end

  // Address stage capture
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s1_vld_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= '0;
      s1_mask_r <= sbp_pkg::MASK_RST;
    end else if (en) begin
      s1_vld_r <= op_go;
      s1_wr_r <= op_wr;
      s1_addr_r <= op_addr;
      // R08: mask taken with its address
      s1_mask_r <= byte_write_mask_n_i;
    end
  end

  // Data stage shift
  // R14: stages drain whatever the select
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s2_vld_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= '0;
      s2_mask_r <= sbp_pkg::MASK_RST;
    end else if (en) begin
      s2_vld_r <= s1_vld_r;
      s2_wr_r <= s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_mask_r <= s1_mask_r;
    end
  end

  // Read word with newer buffered bytes laid over
  always_comb begin
    logic [EW-1:0] ent;
    ent = '0;
    rd_word = mem_r[s2_addr_r];
    for (int k = 0; k < BD; k++) begin
      ent = buf_view[k*EW +: EW];
      if (LVW'(k) < buf_level &&
          ent[sbp_pkg::ENT_ADDR_LSB +: ADDR_W] == s2_addr_r) begin
        for (int b = 0; b < LN; b++) begin
          if (!ent[DW + ADDR_W + b]) begin
            rd_word[b*LW +: LW] = ent[b*LW +: LW];
          end
        end
      end
    end
  end

  // Read data and drive stage
  // R15: data on the second enabled edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      data_o <= '0;
      dq_oe_r <= 1'b0;
    end else if (en) begin
      // R13: drive drops two edges after deselect
      dq_oe_r <= s2_vld_r && !s2_wr_r;
      if (s2_vld_r && !s2_wr_r) begin
        data_o <= rd_word;
      end
    end
  end

  // R17: output enable pin acts without clock
  assign data_oe_o = dq_oe_r && !output_enable_n_i;

  // R05: write word queued at its burst address
  assign buf_in_valid = en && s2_vld_r && s2_wr_r;
  assign buf_in_data = {s2_mask_r, s2_addr_r, data_i};
  // Buffer retires on idle enabled edges, or on write edges when full
  assign buf_out_ready = en && !(s2_vld_r && !s2_wr_r) &&
                         (!s2_vld_r || buf_level == BUF_FULL);
  assign buf_pop = buf_out_valid && buf_out_ready;
  assign wr_buf_ready_o = buf_in_ready;

  // Write buffer between data pins and array
  sbp_fifo #(
    .WIDTH(EW),
    .DEPTH(BD)
  ) u_wbuf (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(buf_in_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data),
    .view_o(buf_view),
    .level_o(buf_level)
  );

  // Array byte-lane write from buffer head
  always_ff @(posedge sys_clk_i) begin
    if (buf_pop) begin
      for (int b = 0; b < LN; b++) begin
        if (!buf_out_data[DW + ADDR_W + b]) begin
          mem_r[buf_out_data[sbp_pkg::ENT_ADDR_LSB +: ADDR_W]][b*LW +: LW]
            <= buf_out_data[b*LW +: LW];
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_rw_ignored: assert property ( // R01
    en && advance_or_load_i && sel && state_r != sbp_pkg::ST_IDLE
    |=> s1_vld_r && s1_wr_r == $past(state_r == sbp_pkg::ST_WR))
    else $error("burst direction changed");

  a_dir_load: assert property ( // R02
    en && load && sel |=> s1_wr_r == !$past(write_n_i)
    ##1 (!$past(en) || (s2_wr_r == !$past(write_n_i, 2))))
    else $error("load direction wrong");
  a_burst_restart: assert property ( // R03
    en && load && sel |=> step_r == 2'h0 && base_r == $past(address_i))
    else $error("load did not restart burst");

  a_step_order: assert property ( // R04
    en && advance_or_load_i && sel && state_r != sbp_pkg::ST_IDLE
    |=> s1_addr_r[ADDR_W-1:SW] == $past(base_r[ADDR_W-1:SW]) &&
        s1_addr_r[SW-1:0] == burst_lo($past(base_r[SW-1:0]),
                                      $past(nxt_step), $past(lbo_r)))
    else $error("burst address wrong");
  a_write_queue: assert property ( // R05
    en && s2_vld_r && s2_wr_r |-> buf_in_ready && buf_in_data[HI+DW+1:DW] == s2_addr_r[HI+1:0])
    else $error("write word not queued");

  a_mask_lead: assert property ( // R08
    (en && load && sel) ##1 en |=> s2_vld_r &&
    s2_mask_r == $past(byte_write_mask_n_i, 2))
    else $error("mask not aligned");
  a_sel_decode: assert property ( // R09
    en && (chip_select_primary_n_i || !chip_select_secondary_i ||
    chip_select_tertiary_n_i) |=> !s1_vld_r)
    else $error("transfer while deselected");

  a_gate_hold: assert property ( // R11
    !en |=> $stable(s1_addr_r) && $stable(step_r) && $stable(state_r) &&
    $stable(data_o) && $stable(dq_oe_r) && $stable(buf_level))
    else $error("state moved on gated edge");
  a_bus_release: assert property ( // R13
    (en && !sel)[*3] |=> !dq_oe_r)
    else $error("bus still driven after deselect");
  a_pending_done: assert property ( // R14
    (en && s1_vld_r && !s1_wr_r) ##1 en |=> dq_oe_r)
    else $error("pending read dropped");
  a_read_latency: assert property ( // R15
    (en && load && sel && write_n_i) ##1 en ##1 en |=> dq_oe_r
    ##1 (!$past(en) || dq_oe_r == $past(s2_vld_r && !s2_wr_r)))
    else $error("read data late");
  a_oe_async: assert property ( // R17
    output_enable_n_i |-> !data_oe_o)
    else $error("driving with output enable off");

  c_read_burst: cover property (
    (en && load && sel && write_n_i) ##1 (en && advance_or_load_i)[*3]);
  c_write_burst: cover property (
    (en && load && sel && !write_n_i) ##1 (en && advance_or_load_i)[*3]);
  c_buf_full: cover property (buf_level == BUF_FULL);
  c_gated: cover property (s1_vld_r && !en ##1 en);
endmodule

// File: tb/sbp_master_model.sv
`timescale 1ns/10ps
// Far-side bus master data lane: sends write words after their capture edge
module sbp_master_model #(
  parameter int W = 36
) (
  input wire logic sys_clk_i,
  input wire logic clock_gate_n_i,
  input wire logic put_i,
  input wire logic [W-1:0] word_i,
  output logic [W-1:0] data_o
);
  logic v1_r = 1'b0; // Word pending, first stage
  logic v2_r = 1'b0; // Word due on the bus
  logic [W-1:0] w1_r = '0; // First stage word
  logic [W-1:0] w2_r = '0; // Word on the bus
  logic [W-1:0] last_r = '0; // Last bus value
  // stages move on enabled edges only
  // word lags its mask by two edges
  always_ff @(posedge sys_clk_i) begin
    if (!clock_gate_n_i) begin
      v1_r <= put_i;
      w1_r <= word_i;
      v2_r <= v1_r;
      w2_r <= w1_r;
    end
    last_r <= data_o;
  end
  // Released lane shows changing junk: the last bus value and its inverse in turn
  assign data_o = v2_r ? w2_r : ~last_r;
endmodule

// File: tb/sbp_tb.sv
`timescale 1ns/10ps
module testbench;
  typedef struct {logic oe; logic [35:0] d;} sbp_exp_t;
  logic clk = 1'b0; // System clock
  logic rst_b, wr_n, adv, burst_order_select, cs1_n, cs2, cs3_n, gate_n, oen, oen_nxt, put, oe, rdy;
  logic [5:0] addr; // Word address
  logic [3:0] mask; // Byte write mask, active low
  logic [35:0] din, dout, word; // Bus data
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  sbp_exp_t q[$]; // Expected outputs in flight
  sbp_exp_t last; // Expectation now on the port
  bit prev_g, act, dir, ord; // Model burst state
  logic [5:0] base; // Burst base
  logic [1:0] step; // Burst step
  logic [8:0] wc = 9'h000; // Write word counter
  logic [35:0] mem [0:63]; // Shadow array

  always #5 clk = ~clk;

  sbp_port #(.ADDR_W(6)) dut (.sys_clk_i(clk), .rst_b_i(rst_b), .address_i(addr), .write_n_i(wr_n),
    .advance_or_load_i(adv), .burst_order_select_i(burst_order_select), .byte_write_mask_n_i(mask),
    .chip_select_primary_n_i(cs1_n), .chip_select_secondary_i(cs2), .chip_select_tertiary_n_i(cs3_n),
    .clock_gate_n_i(gate_n), .output_enable_n_i(oen), .data_i(din), .data_o(dout), .data_oe_o(oe),
    .wr_buf_ready_o(rdy));

  sbp_master_model #(.W(sbp_pkg::DATA_W)) master (.sys_clk_i(clk), .clock_gate_n_i(gate_n),
    .put_i(put), .word_i(word), .data_o(din));

  // Verdict and stop
  task end_of_test;
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One edge: cs 1..3 drops one select, g gates the edge
  task cyc(input logic ad, input logic [5:0] a, input logic w, input logic o, input logic [3:0] m,
           input int cs, input logic g);
    sbp_exp_t e;
    logic [5:0] ea;
    @(posedge clk);
    e.oe = 1'b0;
    e.d = '0;
    if (!g) begin
      if (cs != 0) begin
        act = 1'b0;
      end else if (!ad) begin
        act = 1'b1;
        base = a;
        dir = w;
        ord = o;
        step = 2'h0;
      end else begin
        step = step + 2'h1;
      end
      ea = {base[5:2], ord ? (base[1:0] ^ step) : (base[1:0] + step)};
      if (act && dir) begin
        e.oe = 1'b1;
        e.d = mem[ea];
      end else if (act) begin
        wc = wc + 9'h001;
        for (int b = 0; b < 4; b++) begin
          if (!m[b]) mem[ea][9*b +: 9] = wc;
        end
      end
    end
    adv <= ad;
    addr <= a;
    wr_n <= w;
    burst_order_select <= o;
    mask <= m;
    gate_n <= g;
    oen <= oen_nxt;
    cs1_n <= (cs == 1);
    cs2 <= (cs != 2);
    cs3_n <= (cs == 3);
    put <= !g && act && !dir;
    word <= {4{wc}};
    #1;
    if (!prev_g) last = q.pop_front();
    check_count++;
    // port matches op two enabled edges back
    if (oe !== (last.oe & ~oen) || (last.oe && !oen && dout !== last.d)) begin
      errors++;
      $display("BAD %0t data port mismatch", $time);
    end
    // Write word due on the next edge needs buffer room
    if (!g && master.v2_r && rdy !== 1'b1) begin
      errors++;
      $display("BAD %0t write buffer not ready", $time);
    end
    prev_g = g;
    if (!g) q.push_back(e);
  endtask

  // Deselected edges drain the pipeline
  task flush;
    repeat (3) cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 1, 1'b0);
  endtask

  task t_write_linear;
    cyc(1'b0, 6'h05, 1'b0, 1'b0, 4'h0, 0, 1'b0);
    repeat (3) cyc(1'b1, 6'h3f, 1'b1, 1'b1, 4'h0, 0, 1'b0);
  endtask

  task t_read_interleaved;
    cyc(1'b0, 6'h06, 1'b1, 1'b1, 4'hf, 0, 1'b0);
    repeat (4) cyc(1'b1, 6'h00, 1'b0, 1'b0, 4'h0, 0, 1'b0);
    flush();
  endtask

  task t_mask;
    cyc(1'b0, 6'h07, 1'b0, 1'b0, 4'he, 0, 1'b0);
    cyc(1'b0, 6'h07, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    cyc(1'b0, 6'h05, 1'b0, 1'b1, 4'h6, 0, 1'b0);
    cyc(1'b0, 6'h05, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    flush();
  endtask

  task t_gate;
    cyc(1'b0, 6'h04, 1'b0, 1'b0, 4'h0, 0, 1'b0);
    cyc(1'b0, 6'h3f, 1'b1, 1'b1, 4'hf, 0, 1'b1);
    cyc(1'b0, 6'h04, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    cyc(1'b0, 6'h3f, 1'b0, 1'b1, 4'h0, 2, 1'b1);
    cyc(1'b0, 6'h3f, 1'b0, 1'b0, 4'h0, 0, 1'b1);
    cyc(1'b1, 6'h00, 1'b0, 1'b0, 4'h0, 0, 1'b0);
    flush();
  endtask

  task t_deselect;
    for (int s = 1; s < 4; s++) begin
      cyc(1'b0, 6'h04, 1'b1, 1'b0, 4'hf, 0, 1'b0);
      cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
      cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, s, 1'b0);
      cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
      cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    end
    cyc(1'b0, 6'h09, 1'b0, 1'b0, 4'h0, 0, 1'b0);
    cyc(1'b1, 6'h00, 1'b0, 1'b0, 4'h0, 3, 1'b0);
    flush();
    cyc(1'b0, 6'h09, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    flush();
  endtask

  task t_output_enable;
    cyc(1'b0, 6'h05, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    oen_nxt = 1'b1;
    cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    oen_nxt = 1'b0;
    cyc(1'b1, 6'h00, 1'b1, 1'b0, 4'hf, 0, 1'b0);
    flush();
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    {rst_b, wr_n, burst_order_select, cs1_n, cs3_n, put, oen, oen_nxt} = '0;
    // Advance high with no burst: no transfer on the first edge after reset
    {adv, cs2, gate_n} = 3'b110;
    {addr, mask, word} = '0;
    repeat (3) q.push_back('{1'b0, 36'h0});
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_write_linear();
    t_read_interleaved();
    t_mask();
    t_gate();
    t_deselect();
    t_output_enable();
    end_of_test();
  end
endmodule
